// file: core/ttbc_core.sv
/*
 Tuning and long-term average control for one self proximity channel
 and six projected channels, with settings port and ready pin handling.
 Assumes counts, target and conversion strobes come from logic on clk_i,
 and the register port is driven on link_clk_i.
*/
`timescale 1ns/1ps
module ttbc_core
  import ttbc_pkg::*;
(
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  input wire logic link_clk_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_busy_o,
  input wire logic [ttbc_pkg::NCH-1:0][ttbc_pkg::CW-1:0] count_i,
  input wire logic [ttbc_pkg::CW-1:0] target_i,
  input wire logic [ttbc_pkg::CW-1:0] touch_thr_i,
  input wire logic conv_done_i,
  input wire logic conv_req_i,
  input wire logic [1:0] sens_mult_i,
  input wire logic event_mode_i,
  input wire logic rdy_i,
  output logic rdy_o,
  output logic rdy_oe_n_o,
  output logic conv_start_o,
  output logic [ttbc_pkg::NCH-1:0][ttbc_pkg::CW-1:0] lta_o,
  output logic [ttbc_pkg::NCH-1:0] touch_o,
  output logic tuning_o,
  output logic tune_start_o,
  output logic tune_partial_o,
  output logic [1:0] sens_mult_o,
  output logic comm_window_o
);
  import ttbc_pkg::*;

  ttbc_xfer_if xf ();

  ttbc_state_e state_q;
  logic [7:0] set_q, snap_q;
  logic wr_s1_q, wr_s2_q, wr_seen_q;
  logic rack_s1_q, rack_s2_q, snap_tgl_q;
  logic rs1_q, rs2_q, rs3_q;
  logic [2:0] own_q;
  logic [3:0] tcnt_q;
  logic tuning_q, tstart_q, tend_q, part_q;
  logic [1:0] mult_q;
  logic [6:0] stl_q;
  logic cstart_q, comm_q, rdy_oe_n_q;
  logic [NCH-1:0][CW-1:0] lta_q;
  logic [NCH-1:0] touch_q;
  logic new_wr, freeze, any_oob, auto_req;
  logic acc_force, acc_reseed, start_tune, tune_done;
  logic host_force, comm_open;

  // ==========================================================
  // Register port in the link domain
  ttbc_link_port u_link (
    .link_clk_i(link_clk_i),
    .arst_n_i(arst_n_i),
    .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o),
    .reg_busy_o(reg_busy_o),
    .x(xf.link)
  );

  assign xf.wr_ack_tgl = wr_seen_q;
  assign xf.rd_tgl = snap_tgl_q;
  assign xf.rd_data = snap_q;

  // Outputs straight from flops
  assign lta_o = lta_q;
  assign touch_o = touch_q;
  assign tuning_o = tuning_q;
  assign tune_start_o = tstart_q;
  assign tune_partial_o = part_q;
  assign sens_mult_o = mult_q;
  assign conv_start_o = cstart_q;
  assign comm_window_o = comm_q;
  assign rdy_o = rdy_oe_n_q;
  assign rdy_oe_n_o = rdy_oe_n_q;

  // ==========================================================
  // Control decode
  assign new_wr = (wr_s2_q != wr_seen_q);
  assign freeze = set_q[B_BASELINE_FREEZE];
  assign acc_force = set_q[B_FORCE_RETUNE] && !freeze; // RULE_05 RULE_14
  assign acc_reseed = set_q[B_RESEED] && !freeze; // RULE_06 RULE_14
  assign auto_req = (state_q == ST_IDLE) && conv_done_i && any_oob
                    && !set_q[B_AUTOTUNE_DISABLE]; // RULE_01 RULE_02
  assign start_tune = !freeze
                      && (acc_force || auto_req || (acc_reseed && any_oob)); // RULE_09
  assign tune_done = (state_q == ST_TUNE) && conv_done_i && !start_tune
                     && (tcnt_q == (part_q ? TUNE_PART_LAST : TUNE_FULL_LAST));
  assign host_force = rs3_q && !rs2_q && !(|own_q); // RULE_12

  // Band check over all channels
  always_comb begin
    any_oob = 1'b0;
    for (int i = 0; i < NCH; i++) begin
      any_oob = any_oob
                | ttbc_out_of_band(count_i[i], target_i, set_q[B_WIDE_TUNING_BAND]); // RULE_04
    end
  end

  // Window decision for this cycle
  always_comb begin
    comm_open = host_force; // RULE_12
    if (conv_done_i) begin
      if (state_q == ST_TUNE) begin
        comm_open = comm_open | set_q[B_TUNING_COMM_ENABLE]; // RULE_10 RULE_11
      end else begin
        comm_open = comm_open | !event_mode_i;
      end
    end
    if (event_mode_i && (tstart_q || tend_q)) begin
      comm_open = 1'b1; // RULE_15
    end
  end

  // ==========================================================
  // Synchronisers into the core domain
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_s1_q <= 1'b0;
      wr_s2_q <= 1'b0;
      rack_s1_q <= 1'b0;
      rack_s2_q <= 1'b0;
      rs1_q <= 1'b1;
      rs2_q <= 1'b1;
      rs3_q <= 1'b1;
    end else if (ce_i) begin
      wr_s1_q <= xf.wr_tgl;
      wr_s2_q <= wr_s1_q;
      rack_s1_q <= xf.rd_ack_tgl;
      rack_s2_q <= rack_s1_q;
      rs1_q <= rdy_i;
      rs2_q <= rs1_q;
      rs3_q <= rs2_q;
    end
  end

  // ==========================================================
  // Settings byte; a landing write wins over self-clearing
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      set_q <= SET_RESET;
      wr_seen_q <= 1'b0;
    end else if (ce_i) begin
      if (new_wr) begin
        set_q <= xf.wr_data;
        wr_seen_q <= wr_s2_q;
      end else begin
        if (acc_force) begin
          set_q[B_FORCE_RETUNE] <= 1'b0; // RULE_05 RULE_16
        end
        if (acc_reseed) begin
          set_q[B_RESEED] <= 1'b0; // RULE_06 RULE_16
        end
      end
    end
  end

  // Snapshot published to the link domain
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      snap_q <= SET_RESET;
      snap_tgl_q <= 1'b0;
    end else if (ce_i) begin
      if ((rack_s2_q == snap_tgl_q) && (snap_q != set_q)) begin
        snap_q <= set_q;
        snap_tgl_q <= ~snap_tgl_q;
      end
    end
  end

  // ==========================================================
  // Tuning sequencer
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q <= ST_IDLE;
      tcnt_q <= 4'h0;
      tuning_q <= 1'b0;
      tstart_q <= 1'b0;
      tend_q <= 1'b0;
      part_q <= 1'b0;
      mult_q <= 2'h0;
    end else if (ce_i) begin
      tstart_q <= start_tune;
      tend_q <= tune_done;
      if (start_tune) begin
        state_q <= ST_TUNE;
        tcnt_q <= 4'h0;
        tuning_q <= 1'b1;
        part_q <= set_q[B_PARTIAL_TUNING]; // RULE_03
        mult_q <= sens_mult_i; // RULE_03
      end else begin
        case (state_q)
          ST_IDLE: begin
            tuning_q <= 1'b0;
          end
          ST_TUNE: begin
            if (tune_done) begin
              state_q <= ST_IDLE;
              tuning_q <= 1'b0;
            end else if (conv_done_i) begin
              tcnt_q <= tcnt_q + 4'h1;
            end
          end
          default: begin
            state_q <= ST_IDLE;
            tuning_q <= 1'b0;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Long-term averages and touch states per channel
  for (genvar g = 0; g < NCH; g++) begin : g_ch
    always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        lta_q[g] <= '0;
        touch_q[g] <= 1'b0;
      end else if (ce_i) begin
        if (acc_reseed) begin
          lta_q[g] <= (g == 0) ? count_i[g] - RESEED_OFS
                               : count_i[g] + RESEED_OFS; // RULE_07
          touch_q[g] <= 1'b0; // RULE_08
        end else if (conv_done_i) begin
          touch_q[g] <= ttbc_absdiff(count_i[g], lta_q[g]) > touch_thr_i;
          if (!freeze && (state_q == ST_IDLE)) begin // RULE_14
            if (lta_q[g] < count_i[g]) begin
              lta_q[g] <= lta_q[g] + 16'h0001; // RULE_07
            end else if (lta_q[g] > count_i[g]) begin
              lta_q[g] <= lta_q[g] - 16'h0001;
            end
          end
        end
      end
    end
  end

  // ==========================================================
  // Settling delay before each conversion
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      stl_q <= 7'h00;
      cstart_q <= 1'b0;
    end else if (ce_i) begin
      cstart_q <= (stl_q == 7'h01);
      if (conv_req_i && (stl_q == 7'h00)) begin
        stl_q <= set_q[B_INCREASE_STABILITY] ? 7'(SETTLE_LONG_CYC)
                                             : 7'(SETTLE_CYC); // RULE_13
      end else if (stl_q != 7'h00) begin
        stl_q <= stl_q - 7'h01;
      end
    end
  end

  // ==========================================================
  // Communication window and ready drive
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      comm_q <= 1'b0;
      rdy_oe_n_q <= 1'b1;
      own_q <= 3'h0;
    end else if (ce_i) begin
      comm_q <= comm_open;
      rdy_oe_n_q <= !(comm_open && !host_force); // Pull low to announce
      own_q <= {own_q[1:0], !rdy_oe_n_q}; // Mask our own falling edge
    end
  end

  // ==========================================================
  // Checks
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  a_auto_retune_go: assert property ( // RULE_01
    (ce_i && auto_req && !freeze) |=> (tuning_o && tune_start_o))
    else $error("auto retune did not start");

  a_auto_off_blocks: assert property ( // RULE_02
    (ce_i && !tuning_o && set_q[B_AUTOTUNE_DISABLE] && !set_q[B_FORCE_RETUNE]
     && !set_q[B_RESEED]) |=> !tune_start_o)
    else $error("retune started while auto tuning disabled");

  a_force_retune_go: assert property ( // RULE_05
    (ce_i && acc_force && !new_wr) |=> (tune_start_o && !set_q[B_FORCE_RETUNE]))
    else $error("forced retune not taken or bit not cleared");

  a_reseed_lta_load: assert property ( // RULE_07
    (ce_i && acc_reseed) |=>
      (lta_o[0] == $past(count_i[0]) - RESEED_OFS)
      && (lta_o[1] == $past(count_i[1]) + RESEED_OFS))
    else $error("reseed offsets wrong");

  a_reseed_clear_touch: assert property ( // RULE_08
    (ce_i && acc_reseed) |=> (touch_o == '0))
    else $error("touch state survived reseed");

  a_freeze_holds_lta: assert property ( // RULE_14
    (ce_i && freeze) |=> ((lta_o == $past(lta_o)) && !tune_start_o))
    else $error("average moved or retune under freeze");

  a_tune_no_window: assert property ( // RULE_10
    (ce_i && (state_q == ST_TUNE) && !set_q[B_TUNING_COMM_ENABLE]
     && !host_force && !event_mode_i) |=> !comm_window_o)
    else $error("window opened during tuning");

  a_tune_debug_window: assert property ( // RULE_11
    (ce_i && (state_q == ST_TUNE) && set_q[B_TUNING_COMM_ENABLE] && conv_done_i)
      |=> comm_window_o)
    else $error("no window after charge cycle in debug");

  a_host_forced_window: assert property ( // RULE_12
    (ce_i && host_force) |=> (comm_window_o && rdy_oe_n_o))
    else $error("host forced window not honoured");

  a_event_rdy_pulse: assert property ( // RULE_15
    (ce_i && event_mode_i && tune_start_o && !host_force) |=> !rdy_oe_n_o)
    else $error("ready not pulled at tuning start");

  a_event_end_pulse: assert property ( // RULE_15
    (ce_i && event_mode_i && tend_q && !host_force) |=> !rdy_oe_n_o)
    else $error("ready not pulled at tuning end");

  a_partial_latch: assert property ( // RULE_03
    (ce_i && start_tune && set_q[B_PARTIAL_TUNING])
      |=> (tune_partial_o && (sens_mult_o == $past(sens_mult_i))))
    else $error("partial tuning or multiplier not latched");

  a_reseed_self_clear: assert property ( // RULE_06
    (ce_i && acc_reseed && !new_wr) |=> !set_q[B_RESEED])
    else $error("reseed bit not cleared");

  a_reseed_oob_tune: assert property ( // RULE_09
    (ce_i && acc_reseed && any_oob) |=> (tuning_o && tune_start_o))
    else $error("reseed out of band did not retune");
endmodule : ttbc_core

// file: core/ttbc_link_port.sv
/*
 Link-clock register port for the settings byte.
 Assumes the core acknowledges each write toggle and publishes its
 settings snapshot by toggle, holding data until acknowledged.
*/
`timescale 1ns/1ps
module ttbc_link_port
  import ttbc_pkg::*;
(
  input wire logic link_clk_i,
  input wire logic arst_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_busy_o,
  ttbc_xfer_if.link x
);
  import ttbc_pkg::*;

  logic ack_s1_q, ack_s2_q;
  logic rd_s1_q, rd_s2_q;
  logic wr_tgl_q, rd_ack_q, busy_q;
  logic [7:0] wr_data_q, shadow_q, rdata_q;
  logic sel;

  assign sel = (reg_addr_i == SET_OFFSET);
  assign x.wr_tgl = wr_tgl_q;
  assign x.wr_data = wr_data_q;
  assign x.rd_ack_tgl = rd_ack_q;
  assign reg_rdata_o = rdata_q;
  assign reg_busy_o = busy_q;

  // ==========================================================
  // Synchronisers for the toggles coming from the core
  always_ff @(posedge link_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
      rd_s1_q <= 1'b0;
      rd_s2_q <= 1'b0;
    end else begin
      ack_s1_q <= x.wr_ack_tgl;
      ack_s2_q <= ack_s1_q;
      rd_s1_q <= x.rd_tgl;
      rd_s2_q <= rd_s1_q;
    end
  end

  // ==========================================================
  // Write launch; a write while busy is dropped
  always_ff @(posedge link_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_tgl_q <= 1'b0;
      wr_data_q <= SET_RESET;
      busy_q <= 1'b0;
    end else begin
      if (reg_wr_i && sel && !busy_q && (wr_tgl_q == ack_s2_q)) begin
        wr_data_q <= reg_wdata_i;
        wr_tgl_q <= ~wr_tgl_q;
        busy_q <= 1'b1;
      end else begin
        busy_q <= (wr_tgl_q != ack_s2_q);
      end
    end
  end

  // ==========================================================
  // Read shadow of the core settings, registered read data
  always_ff @(posedge link_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      shadow_q <= SET_RESET;
      rd_ack_q <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      if (rd_s2_q != rd_ack_q) begin
        shadow_q <= x.rd_data;
        rd_ack_q <= rd_s2_q;
      end
      rdata_q <= sel ? shadow_q : 8'h00; // Unmapped reads zero
    end
  end
endmodule : ttbc_link_port

// file: core/ttbc_pkg.sv
/*
 Constants, field layout and helpers for the tuning and baseline control.
 Assumes one settings byte at offset 0x80, a 20 MHz core clock and
 16-bit channel counts, channel 0 being the self proximity channel.
*/
// Behaviour
// RULE_01: Retune automatically when counts leave band.
// RULE_02: Disable bit blocks only automatic retuning.
// RULE_03: Partial tuning uses host sensitivity option 1-4.
// RULE_04: Band is target/8, target/4 when wide.
// RULE_05: Forced retune starts at once, bit self-clears.
// RULE_06: Reseed bit reseeds averages, then self-clears.
// RULE_07: Reseed: projected count+8, self count-8, track.
// RULE_08: Reseed clears all proximity and touch states.
// RULE_09: Reseed with counts outside band triggers retune.
// RULE_10: No communication windows while tuning by default.
// RULE_11: Comm enable opens window each cycle tuning.
// RULE_12: Host pulling ready low always forces window; code acts only on a falling edge not masked by own_q.
// RULE_13: Stability bit lengthens analogue settling interval.
// RULE_14: Freeze holds averages, blocks reseed and retune.
// RULE_15: Event mode pulses ready at tuning start/end.
// RULE_16: Self-clearing bits read zero once accepted.
package ttbc_pkg;
  // ==========================================================
  // Sizes and register map
  localparam int NCH = 7;
  localparam int CW = 16;
  localparam logic [7:0] SET_OFFSET = 8'h80;
  localparam logic [7:0] SET_RESET = 8'h00;
  localparam int B_AUTOTUNE_DISABLE = 0;
  localparam int B_PARTIAL_TUNING = 1;
  localparam int B_WIDE_TUNING_BAND = 2;
  localparam int B_FORCE_RETUNE = 3;
  localparam int B_RESEED = 4;
  localparam int B_TUNING_COMM_ENABLE = 5;
  localparam int B_INCREASE_STABILITY = 6;
  localparam int B_BASELINE_FREEZE = 7;
  localparam logic [CW-1:0] RESEED_OFS = 16'h0008;

  // ==========================================================
  // Timing
  localparam int CLK_HZ = 20_000_000;
  localparam int SETTLE_NS = 1000;
  localparam int SETTLE_LONG_NS = 4000;
  localparam int SETTLE_CYC = (SETTLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int SETTLE_LONG_CYC = (SETTLE_LONG_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam logic [3:0] TUNE_FULL_LAST = 4'hF;
  localparam logic [3:0] TUNE_PART_LAST = 4'h3;

  typedef enum logic {ST_IDLE, ST_TUNE} ttbc_state_e;

  // ==========================================================
  // Helpers
  function automatic logic [CW-1:0] ttbc_absdiff(input logic [CW-1:0] a,
                                                 input logic [CW-1:0] b);
    return (a > b) ? a - b : b - a;
  endfunction : ttbc_absdiff

  function automatic logic ttbc_out_of_band(input logic [CW-1:0] cnt,
                                            input logic [CW-1:0] tgt,
                                            input logic wide);
    logic [CW-1:0] band;
    band = wide ? (tgt >> 2) : (tgt >> 3);
    return ttbc_absdiff(cnt, tgt) > band;
  endfunction : ttbc_out_of_band
endpackage : ttbc_pkg

// file: core/ttbc_xfer_if.sv
/*
 Crossing signals between the link-side register port and the core.
 Assumes toggle handshakes: data is held until the toggle is acknowledged.
*/
`timescale 1ns/1ps
interface ttbc_xfer_if;
  logic wr_tgl;
  logic [7:0] wr_data;
  logic wr_ack_tgl;
  logic rd_tgl;
  logic [7:0] rd_data;
  logic rd_ack_tgl;
  modport link (output wr_tgl, wr_data, rd_ack_tgl, input wr_ack_tgl, rd_tgl, rd_data);
  modport core (input wr_tgl, wr_data, rd_ack_tgl, output wr_ack_tgl, rd_tgl, rd_data);
endinterface : ttbc_xfer_if

// file: tb/touch_tuning_baseline_ctrl_tb.sv
/*
 Self-checking bench for the tuning and baseline control core.
 Assumes the core and host model in core/ and tb/; clocks made here.
*/
`timescale 1ns/1ps
module touch_tuning_baseline_ctrl_tb;
  import ttbc_pkg::*;
  typedef struct packed {logic [7:0] set; logic [15:0] dlt; logic tune;} ttbc_row_s;
  localparam logic [15:0] TGT = 16'h0400;
  logic clk_i = 1'b0;
  logic link_clk_i;
  logic arst_n_i = 1'b0;
  logic [NCH-1:0][CW-1:0] count_i = {NCH{TGT}};
  logic conv_done_i = 1'b0;
  logic conv_req_i = 1'b0;
  logic event_mode_i = 1'b0;
  logic [7:0] addr, wdata, rdata, rd;
  logic wr, busy, rdy_line, rdy_o, rdy_oe_n_o, conv_start_o, tuning_o;
  logic tune_start_o, tune_partial_o, comm_window_o;
  logic [1:0] sens_mult_o;
  logic [NCH-1:0][CW-1:0] lta_o;
  logic [NCH-1:0] touch_o;
  int error_cnt = 0;
  int compares = 0;
  int cyc = 0;
  int ts_cnt = 0;
  int win_cnt = 0;
  int oe_cnt = 0;
  int cs_cyc = 0;
  int t, w, len;
  logic [15:0] l;
  ttbc_row_s rows [7] = '{'{8'h00, 16'h0080, 1'b0}, '{8'h00, 16'h0081, 1'b1},
    '{8'h04, 16'h0100, 1'b0}, '{8'h04, 16'h0101, 1'b1}, '{8'h01, 16'h0190, 1'b0},
    '{8'h02, 16'h0190, 1'b1}, '{8'h20, 16'h0190, 1'b1}};

  // ==========================================================
  // Clocks: core 50 ns, link 12 ns with an unrelated phase
  always #25 clk_i = ~clk_i;
  initial begin
    link_clk_i = 1'b0;
    #2.5;
    forever #6 link_clk_i = ~link_clk_i;
  end

  ttbc_core i_dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .ce_i(1'b1),
    .link_clk_i(link_clk_i), .reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wdata),
    .reg_rdata_o(rdata), .reg_busy_o(busy), .count_i(count_i), .target_i(TGT),
    .touch_thr_i(16'h0020), .conv_done_i(conv_done_i), .conv_req_i(conv_req_i),
    .sens_mult_i(2'h2), .event_mode_i(event_mode_i), .rdy_i(rdy_line), .rdy_o(rdy_o),
    .rdy_oe_n_o(rdy_oe_n_o), .conv_start_o(conv_start_o), .lta_o(lta_o),
    .touch_o(touch_o), .tuning_o(tuning_o), .tune_start_o(tune_start_o),
    .tune_partial_o(tune_partial_o), .sens_mult_o(sens_mult_o),
    .comm_window_o(comm_window_o));

  ttbc_host_model i_host (.link_clk_i(link_clk_i), .rdata_i(rdata), .busy_i(busy),
    .dev_rdy_i(rdy_o), .dev_oe_n_i(rdy_oe_n_o), .addr_o(addr), .wr_o(wr),
    .wdata_o(wdata), .rdy_line_o(rdy_line));

  // Event monitors: pulses and ready drive cycles
  always @(posedge clk_i) begin
    cyc = cyc + 1;
    if (tune_start_o === 1'b1) ts_cnt++;
    if (comm_window_o === 1'b1) win_cnt++;
    if (rdy_oe_n_o === 1'b0) oe_cnt++;
    if (conv_start_o === 1'b1) cs_cyc = cyc - 1;
  end

  // ==========================================================
  // Helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string m);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, m, seen, exp);
    end
  endtask : check

  task automatic conv(input int n);
    repeat (n) begin
      @(negedge clk_i);
      conv_done_i = 1'b1;
      @(negedge clk_i);
      conv_done_i = 1'b0;
      repeat (2) @(negedge clk_i);
    end
  endtask : conv

  task automatic wclk(input int n);
    repeat (n) @(negedge clk_i);
  endtask : wclk

  task automatic finish_test;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : finish_test

  // Watchdog against a hung handshake
  initial begin
    #1_000_000;
    error_cnt++;
    finish_test();
  end

  // ==========================================================
  // Main sequence
  initial begin
    wclk(5);
    check(rdy_oe_n_o, 1'b1, "ready released in reset");
    check(rdy_o, 1'b1, "ready level in reset");
    arst_n_i = 1'b1;
    wclk(2);
    check(tuning_o, 1'b0, "idle after reset");
    i_host.read_reg(8'h80, rd);
    check(rd, 8'h00, "settings reset");
    $display("test reset done");
    for (int i = 0; i < 7; i++) begin
      i_host.write_reg(8'h80, rows[i].set);
      wclk(4);
      t = ts_cnt;
      w = win_cnt;
      @(negedge clk_i);
      count_i[0] = TGT + rows[i].dlt;
      conv(1);
      count_i[0] = TGT;
      check(ts_cnt - t, rows[i].tune, "auto retune");
      if (rows[i].tune) begin
        len = rows[i].set[1] ? 3 : 15;
        w = win_cnt;
        conv(len);
        check(tuning_o, 1'b1, "still tuning");
        check(win_cnt - w, rows[i].set[5] ? len : 0, "tune windows");
        conv(1);
        check(tuning_o, 1'b0, "tune length");
        if (rows[i].set[1]) check({tune_partial_o, sens_mult_o}, 3'h6, "partial");
      end else begin
        check(win_cnt - w, 1, "idle window");
      end
      $display("test row %0d done", i);
    end
    // Forced retune with autotune disabled, host window mid-tune
    t = ts_cnt;
    i_host.write_reg(8'h80, 8'h09);
    wclk(4);
    check(ts_cnt - t, 1, "forced retune");
    i_host.read_reg(8'h80, rd);
    check(rd, 8'h01, "force bit cleared");
    w = win_cnt;
    i_host.pull_ready(10);
    wclk(8);
    check(win_cnt - w, 1, "host window");
    conv(16);
    check(tuning_o, 1'b0, "forced tune end");
    $display("test force done");
    // Reseed: offsets, cleared touch, tracking, retune when out of band
    i_host.write_reg(8'h80, 8'h00);
    conv(1);
    check(touch_o, 7'h7F, "touch set");
    i_host.write_reg(8'h80, 8'h10);
    wclk(4);
    check(touch_o, 7'h00, "reseed clears");
    check(lta_o[0], TGT - 16'h0008, "self reseed");
    check(lta_o[3], TGT + 16'h0008, "proj reseed");
    i_host.read_reg(8'h80, rd);
    check(rd, 8'h00, "reseed bit cleared");
    conv(1);
    check(lta_o[0], TGT - 16'h0007, "self tracks");
    check(lta_o[3], TGT + 16'h0007, "proj tracks");
    t = ts_cnt;
    @(negedge clk_i);
    count_i[2] = TGT + 16'h0190;
    i_host.write_reg(8'h80, 8'h10);
    wclk(4);
    check(ts_cnt - t, 1, "reseed retune");
    count_i[2] = TGT;
    conv(16);
    $display("test reseed done");
    // Freeze with pending force and out-of-band counts
    i_host.write_reg(8'h80, 8'h88);
    wclk(4);
    t = ts_cnt;
    l = lta_o[0];
    count_i[1] = TGT + 16'h0190;
    conv(2);
    count_i[1] = TGT;
    check(ts_cnt - t, 0, "frozen retune");
    check(lta_o[0], l, "frozen average");
    i_host.read_reg(8'h80, rd);
    check(rd, 8'h88, "force pending");
    i_host.write_reg(8'h80, 8'h00);
    $display("test freeze done");
    // Event mode: ready pulled at tune start and end
    @(negedge clk_i);
    event_mode_i = 1'b1;
    w = oe_cnt;
    i_host.write_reg(8'h80, 8'h08);
    wclk(4);
    check(oe_cnt - w, 1, "ready at start");
    conv(16);
    check(oe_cnt - w, 2, "ready at end");
    event_mode_i = 1'b0;
    $display("test event done");
    // Unmapped address is ignored
    i_host.write_reg(8'h81, 8'hFF);
    i_host.read_reg(8'h80, rd);
    check(rd, 8'h00, "unmapped write");
    i_host.read_reg(8'h81, rd);
    check(rd, 8'h00, "unmapped read");
    // Settle interval, normal then long
    for (int s = 0; s < 2; s++) begin
      i_host.write_reg(8'h80, s ? 8'h40 : 8'h00);
      wclk(4);
      @(negedge clk_i);
      conv_req_i = 1'b1;
      @(posedge clk_i);
      #1 t = cyc;
      @(negedge clk_i);
      conv_req_i = 1'b0;
      wclk(100);
      check(cs_cyc - t, s ? SETTLE_LONG_CYC : SETTLE_CYC, "settle");
    end
    $display("test settle done");
    check(i_host.faults, 0, "busy handshake");
    finish_test();
  end
endmodule : touch_tuning_baseline_ctrl_tb

// file: tb/ttbc_host_model.sv
/*
 Host side of the settings port and of the ready line.
 Assumes the device drives ready low only while its enable is low,
 and that the line has a pull-up.
*/
`timescale 1ns/1ps
module ttbc_host_model (
  input wire logic link_clk_i,
  input wire logic [7:0] rdata_i,
  input wire logic busy_i,
  input wire logic dev_rdy_i,
  input wire logic dev_oe_n_i,
  output logic [7:0] addr_o,
  output logic wr_o,
  output logic [7:0] wdata_o,
  output logic rdy_line_o
);
  // ==========================================================
  // Ready line: pulled up unless a party drives it low
  logic pull_q = 1'b0;
  int faults = 0;
  assign rdy_line_o = (pull_q || (!dev_oe_n_i && !dev_rdy_i)) ? 1'b0 : 1'b1;

  // Idle bus values
  initial begin
    addr_o = 8'h80;
    wr_o = 1'b0;
    wdata_o = 8'h00;
  end

  // One byte write; a mapped write waits until busy clears
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(negedge link_clk_i);
    addr_o = a;
    wdata_o = d;
    wr_o = 1'b1;
    @(negedge link_clk_i);
    wr_o = 1'b0;
    wdata_o = ~d; // Stale data must not look valid
    repeat (3) @(negedge link_clk_i);
    while (busy_i !== 1'b0 && n < 200) begin
      @(negedge link_clk_i);
      n++;
    end
    if (n >= 200) faults++;
    addr_o = 8'h80;
  endtask : write_reg

  // Read after the address has settled for two edges
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    repeat (40) @(negedge link_clk_i); // Let a just-written value reach the read shadow
    @(negedge link_clk_i);
    addr_o = a;
    repeat (2) @(negedge link_clk_i);
    d = rdata_i;
    addr_o = 8'h80;
  endtask : read_reg

  // Host handshake: hold ready low for a number of link cycles
  task automatic pull_ready(input int cyc);
    pull_q = 1'b1;
    repeat (cyc) @(negedge link_clk_i);
    pull_q = 1'b0;
  endtask : pull_ready
endmodule : ttbc_host_model
